// File: ecit_defs.svh
// Purpose: Register indices, field positions, reset values and timing for the capture timer.
// Assumes: Byte address of a register is four times its index.
// Notes: Definitions only.
`ifndef ECIT_DEFS_SVH
`define ECIT_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define ECIT_IDX_FREE_LO 6'h20
`define ECIT_IDX_FREE_HI 6'h21
`define ECIT_IDX_C0R 6'h22
`define ECIT_IDX_C1R 6'h23
`define ECIT_IDX_C0F 6'h24
`define ECIT_IDX_C1F 6'h25
`define ECIT_IDX_IVL_LO 6'h26
`define ECIT_IDX_IVL_HI 6'h27
`define ECIT_IDX_RLD_LO 6'h28
`define ECIT_IDX_RLD_HI 6'h29
`define ECIT_IDX_CFG 6'h2a
`define ECIT_IDX_IEN 6'h2b
`define ECIT_IDX_IST 6'h2c

// ----------------------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------------------
`define ECIT_CFG_HOLD 7
`define ECIT_CFG_PSC_HI 6
`define ECIT_CFG_PSC_LO 4
`define ECIT_CFG_CHAIN 3
`define ECIT_CFG_MASK 8'hf8
`define ECIT_NIB_MASK 8'h0f
`define ECIT_RST_BYTE 8'h00
`define ECIT_RESP_OKAY 2'h0
`define ECIT_RESP_SLVERR 2'h2
`define ECIT_IVL_TICK_NS 1000
`define ECIT_MCLK_NS 20

`endif

// File: ecit_pkg.sv
// Purpose: Shared types of the capture timer.
// Assumes: Nothing beyond the header.
// Notes: Edge order matches the enable and status bit order.
package ecit_pkg;
  typedef logic [7:0] ecit_byte_t;
  typedef enum logic [1:0] {ECIT_C0_RISE, ECIT_C0_FALL, ECIT_C1_RISE, ECIT_C1_FALL} ecit_edge_t;
endpackage

// File: ecit_cap_if.sv
// Purpose: Carries one capture register between the top and its store.
// Assumes: One clock.
// Notes: Owner drives the controls, store returns value and full flag.
`timescale 1ns/1ns
interface ecit_cap_if;
  logic load;
  logic wr;
  logic clr;
  logic hold;
  ecit_pkg::ecit_byte_t sample;
  ecit_pkg::ecit_byte_t value;
  logic full;
  modport owner (output load, wr, clr, hold, sample, input value, full);
  modport store (input load, wr, clr, hold, sample, output value, full);
endinterface

// File: ecit_edge_det.sv
// Purpose: Finds rising and falling edges of a capture input.
// Assumes: Input is synchronous to mclk.
// Notes: Pulses last one cycle.
`timescale 1ns/1ns
module ecit_edge_det (
  input logic mclk,
  input logic arst_n,
  input logic pin,
  output logic rise,
  output logic fall
);
  logic last;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      last <= 1'b0;
    else
      last <= pin;
  end

  assign rise = pin & ~last;
  assign fall = ~pin & last;
endmodule

// File: ecit_cap_store.sv
// Purpose: One capture register with first-edge hold.
// Assumes: Load and clear are one-cycle pulses.
// Notes: A software write always stores and frees the register.
`timescale 1ns/1ns
`include "ecit_defs.svh"
module ecit_cap_store (
  input logic mclk,
  input logic arst_n,
  ecit_cap_if.store c
);
  logic take;

  assign take = c.wr | (c.load & (~c.hold | ~c.full | c.clr));

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      c.value <= `ECIT_RST_BYTE;
      c.full <= 1'b0;
    end
    else
    begin
      if (take)
        c.value <= c.sample;
      c.full <= (c.load & take & ~c.wr) | (c.full & ~c.clr & ~c.wr);
    end
  end
endmodule

// File: ecit_top.sv
// Purpose: Edge capture timer with interval timer behind an AXI4-Lite slave.
// Assumes: Capture inputs synchronous to mclk; one write and one read at a time.
// Notes: Byte address is four times the register index; data in bits 7:0.
`timescale 1ns/1ns
`include "ecit_defs.svh"

// Notes on behaviour
// - Channel 1 falling edge stores the timer value in its falling register.
// - In 8-bit capture the prescale field picks the stored count slice.
// - Prescale code n stores count bits n+7 down to n.
// - In 16-bit mode channel 0 falling loads count high byte into channel 1 fall.
// - Chain bit disables channel 1 and makes its registers upper bytes.
// - Hold clear: every qualifying edge overwrites; the latest time is read.
// - Hold set: first edge kept, later edges ignored until the register is read.
// - Interval count is 12 bits; low byte read latches the upper nibble.
// - Interval high read returns the latched nibble; bits 7:4 read zero.
// - Reload is 12 bits: low byte register plus high register nibble.
// - Enable bits: 3 ch1 fall, 2 ch1 rise, 1 ch0 fall, 0 ch0 rise.
// - The free-running timer is a 16-bit counter.
// - In 16-bit mode channel 0 registers hold the count low byte.
module ecit_top #(
  parameter int ADDR_W = 8,
  parameter int FREE_W = 16,
  parameter int IVL_W = 12,
  parameter int IVL_DIV = (`ECIT_IVL_TICK_NS + `ECIT_MCLK_NS - 1) / `ECIT_MCLK_NS
) (
  input logic mclk,
  input logic arst_n,
  input logic capture_zero_input,
  input logic capture_one_input,
  input logic [ADDR_W-1:0] s_axi_awaddr,
  input logic [2:0] s_axi_awprot,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [ADDR_W-1:0] s_axi_araddr,
  input logic [2:0] s_axi_arprot,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  output logic [3:0] cap_irq
);
  // --------------------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------------------
  if (FREE_W != 16 || IVL_W != 12 || ADDR_W < 8 || IVL_DIV < 1)
  begin : g_bad_param
    $error("ecit_top: unsupported parameter values");
  end

  // --------------------------------------------------------------------------
  // Decoding functions
  // --------------------------------------------------------------------------
  function automatic logic is_mapped(input logic [5:0] idx);
    is_mapped = (idx >= `ECIT_IDX_FREE_LO) && (idx <= `ECIT_IDX_IST);
  endfunction

  function automatic logic [1:0] cap_slot(input logic [5:0] idx);
    case (idx)
      `ECIT_IDX_C0R: cap_slot = 2'h0;
      `ECIT_IDX_C0F: cap_slot = 2'h1;
      `ECIT_IDX_C1R: cap_slot = 2'h2;
      default: cap_slot = 2'h3;
    endcase
  endfunction

  function automatic logic is_cap(input logic [5:0] idx);
    is_cap = (idx >= `ECIT_IDX_C0R) && (idx <= `ECIT_IDX_C1F);
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [FREE_W-1:0] free_cnt;
  ecit_pkg::ecit_byte_t free_hold;
  ecit_pkg::ecit_byte_t free_wr_low;
  logic [IVL_W-1:0] ivl_cnt;
  logic [3:0] ivl_hold;
  logic [IVL_W-1:0] reload;
  ecit_pkg::ecit_byte_t timer_config;
  logic [3:0] capture_irq_enable;
  logic [3:0] capture_irq_status;
  logic [15:0] div_cnt;
  logic tick;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire wr_take = s_axi_awvalid & s_axi_awready;
  wire rd_take = s_axi_arvalid & s_axi_arready;
  wire [5:0] wr_idx = s_axi_awaddr[7:2];
  wire [5:0] rd_idx = s_axi_araddr[7:2];
  wire wr_ok = wr_take & is_mapped(wr_idx) & s_axi_wstrb[0];
  wire rd_ok = rd_take & is_mapped(rd_idx);
  wire [7:0] wbyte = s_axi_wdata[7:0];
  wire wr_free_lo = wr_ok && wr_idx == `ECIT_IDX_FREE_LO;
  wire wr_free_hi = wr_ok && wr_idx == `ECIT_IDX_FREE_HI;
  wire wr_ivl_lo = wr_ok && wr_idx == `ECIT_IDX_IVL_LO;
  wire wr_ivl_hi = wr_ok && wr_idx == `ECIT_IDX_IVL_HI;
  wire wr_rld_lo = wr_ok && wr_idx == `ECIT_IDX_RLD_LO;
  wire wr_rld_hi = wr_ok && wr_idx == `ECIT_IDX_RLD_HI;
  wire wr_cfg = wr_ok && wr_idx == `ECIT_IDX_CFG;
  wire wr_ien = wr_ok && wr_idx == `ECIT_IDX_IEN;
  wire wr_ist = wr_ok && wr_idx == `ECIT_IDX_IST;
  wire rd_free_lo = rd_ok && rd_idx == `ECIT_IDX_FREE_LO;
  wire rd_ivl_lo = rd_ok && rd_idx == `ECIT_IDX_IVL_LO;

  // --------------------------------------------------------------------------
  // Configuration fields
  // --------------------------------------------------------------------------
  wire hold_first = timer_config[`ECIT_CFG_HOLD];
  wire chain = timer_config[`ECIT_CFG_CHAIN];
  wire [2:0] psc = timer_config[`ECIT_CFG_PSC_HI:`ECIT_CFG_PSC_LO];
  wire [FREE_W-1:0] shifted = free_cnt >> psc;
  wire [7:0] slice = shifted[7:0];

  // --------------------------------------------------------------------------
  // Edges and capture stores
  // --------------------------------------------------------------------------
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;
  wire [1:0] pins = {capture_one_input, capture_zero_input};
  logic [3:0] evt;
  ecit_cap_if cap [4] ();

  genvar gi;
  for (gi = 0; gi < 2; gi++)
  begin : g_edge
    ecit_edge_det u_edge (
      .mclk(mclk),
      .arst_n(arst_n),
      .pin(pins[gi]),
      .rise(pin_rise[gi]),
      .fall(pin_fall[gi])
    );
  end

  assign evt[ecit_pkg::ECIT_C0_RISE] = pin_rise[0];
  assign evt[ecit_pkg::ECIT_C0_FALL] = pin_fall[0];
  assign evt[ecit_pkg::ECIT_C1_RISE] = pin_rise[1] & ~chain;
  assign evt[ecit_pkg::ECIT_C1_FALL] = pin_fall[1] & ~chain;

  for (gi = 0; gi < 4; gi++)
  begin : g_cap
    wire hit_rd = rd_ok && is_cap(rd_idx) && cap_slot(rd_idx) == gi;
    wire hit_wr = wr_ok && is_cap(wr_idx) && cap_slot(wr_idx) == gi;
    wire [7:0] wide = (gi < 2) ? free_cnt[7:0] : free_cnt[15:8];
    assign cap[gi].load = chain ? evt[gi % 2] : evt[gi];
    assign cap[gi].sample = hit_wr ? wbyte : (chain ? wide : slice);
    assign cap[gi].wr = hit_wr;
    assign cap[gi].clr = hit_rd;
    assign cap[gi].hold = hold_first;
    ecit_cap_store u_store (
      .mclk(mclk),
      .arst_n(arst_n),
      .c(cap[gi])
    );
  end

  // --------------------------------------------------------------------------
  // Read data selection
  // --------------------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb
  begin
    case (rd_idx)
      `ECIT_IDX_FREE_LO: rd_byte = free_cnt[7:0];
      `ECIT_IDX_FREE_HI: rd_byte = free_hold;
      `ECIT_IDX_C0R: rd_byte = cap[0].value;
      `ECIT_IDX_C0F: rd_byte = cap[1].value;
      `ECIT_IDX_C1R: rd_byte = cap[2].value;
      `ECIT_IDX_C1F: rd_byte = cap[3].value;
      `ECIT_IDX_IVL_LO: rd_byte = ivl_cnt[7:0];
      `ECIT_IDX_IVL_HI: rd_byte = {4'h0, ivl_hold};
      `ECIT_IDX_RLD_LO: rd_byte = reload[7:0];
      `ECIT_IDX_RLD_HI: rd_byte = {4'h0, reload[11:8]};
      `ECIT_IDX_CFG: rd_byte = timer_config;
      `ECIT_IDX_IEN: rd_byte = {4'h0, capture_irq_enable};
      `ECIT_IDX_IST: rd_byte = {4'h0, capture_irq_status};
      default: rd_byte = `ECIT_RST_BYTE;
    endcase
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite handshakes
  // --------------------------------------------------------------------------
  wire next_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
  wire next_arready = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ECIT_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `ECIT_RESP_OKAY;
      s_axi_rdata <= 32'h0;
    end
    else
    begin
      s_axi_awready <= next_awready;
      s_axi_wready <= next_awready;
      s_axi_arready <= next_arready;
      if (wr_take)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(wr_idx) ? `ECIT_RESP_OKAY : `ECIT_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rd_ok ? `ECIT_RESP_OKAY : `ECIT_RESP_SLVERR;
        s_axi_rdata <= {24'h0, rd_byte};
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Free-running and interval timers
  // --------------------------------------------------------------------------
  assign tick = (div_cnt == 16'(IVL_DIV - 1));

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      free_cnt <= '0;
      free_hold <= `ECIT_RST_BYTE;
      free_wr_low <= `ECIT_RST_BYTE;
      div_cnt <= 16'h0;
    end
    else
    begin
      div_cnt <= tick ? 16'h0 : div_cnt + 16'h1;
      free_cnt <= wr_free_hi ? {wbyte, free_wr_low} : free_cnt + 16'h1;
      if (wr_free_lo)
        free_wr_low <= wbyte;
      if (rd_free_lo)
        free_hold <= free_cnt[15:8];
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ivl_cnt <= '0;
      ivl_hold <= 4'h0;
      reload <= '0;
    end
    else
    begin
      if (wr_ivl_lo)
        ivl_cnt[7:0] <= wbyte;
      else if (wr_ivl_hi)
        ivl_cnt[11:8] <= wbyte[3:0];
      else if (tick)
        ivl_cnt <= (ivl_cnt == '0) ? reload : ivl_cnt - 12'h1;
      if (rd_ivl_lo)
        ivl_hold <= ivl_cnt[11:8];
      if (wr_rld_lo)
        reload[7:0] <= wbyte;
      if (wr_rld_hi)
        reload[11:8] <= wbyte[3:0];
    end
  end

  // --------------------------------------------------------------------------
  // Configuration, enables, status and requests
  // --------------------------------------------------------------------------
  wire [3:0] ist_clr = wr_ist ? wbyte[3:0] : 4'h0;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      timer_config <= `ECIT_RST_BYTE;
      capture_irq_enable <= 4'h0;
      capture_irq_status <= 4'h0;
      cap_irq <= 4'h0;
    end
    else
    begin
      if (wr_cfg)
        timer_config <= wbyte & `ECIT_CFG_MASK;
      if (wr_ien)
        capture_irq_enable <= wbyte[3:0];
      capture_irq_status <= evt | (capture_irq_status & ~ist_clr);
      cap_irq <= capture_irq_status & capture_irq_enable;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  fall_one_cap_a: assert property (evt[3] && !hold_first && !g_cap[3].hit_wr
    |=> cap[3].value == $past(slice)) else $error("channel 1 fall not captured");
  slice_pick_a: assert property (evt[0] && !chain && !hold_first && !g_cap[0].hit_wr
    |=> cap[0].value == 8'($past(free_cnt) >> $past(psc))) else $error("wrong slice");
  slice_top_a: assert property (evt[0] && !chain && !hold_first && psc == 3'h7
    && !g_cap[0].hit_wr |=> cap[0].value == $past(free_cnt[14:7])) else $error("slice 7 bad");
  chain_fall_a: assert property (chain && pin_fall[0] && !hold_first && !g_cap[3].hit_wr
    |=> cap[3].value == $past(free_cnt[15:8])) else $error("chain upper byte bad");
  chain_block_a: assert property (chain && pin_rise[1] && !pin_rise[0]
    && !g_cap[2].hit_wr |=> $stable(cap[2].value) && !capture_irq_status[2] || $past(capture_irq_status[2]))
    else $error("channel 1 active in chain mode");
  hold_keep_a: assert property (hold_first && cap[1].full && !cap[1].clr && !cap[1].wr
    |=> $stable(cap[1].value)) else $error("held capture overwritten");
  latest_edge_a: assert property (!hold_first && cap[0].load && !cap[0].wr
    |=> cap[0].value == $past(cap[0].sample)) else $error("latest edge lost");
  chain_low_a: assert property (chain && pin_rise[0] && !hold_first && !g_cap[0].hit_wr
    |=> cap[0].value == $past(free_cnt[7:0])) else $error("chain low byte bad");
  nib_latch_a: assert property (rd_ivl_lo |=> ivl_hold == $past(ivl_cnt[11:8]))
    else $error("nibble not latched");
  hi_read_a: assert property (rd_take && rd_idx == `ECIT_IDX_IVL_HI
    |=> s_axi_rdata == {28'h0, $past(ivl_hold)}) else $error("interval high read bad");
  reload_hi_a: assert property (wr_rld_hi |=> reload[11:8] == $past(wbyte[3:0]))
    else $error("reload nibble not stored");
  status_set_a: assert property (evt[2] |=> capture_irq_status[2])
    else $error("status flag missed");
  irq_gate_a: assert property (cap_irq[1] |-> $past(capture_irq_status[1])
    && $past(capture_irq_enable[1])) else $error("request without flag and enable");
  enable_read_a: assert property (rd_take && rd_idx == `ECIT_IDX_IEN
    |=> s_axi_rdata == {28'h0, $past(capture_irq_enable)}) else $error("enable readback bad");

  chain_cap_c: cover property (chain && pin_fall[0]);
  hold_ignore_c: cover property (hold_first && cap[0].full && cap[0].load);
  irq_raise_c: cover property (cap_irq[1]);
  nib_read_c: cover property (rd_ivl_lo ##[1:60] rd_take && rd_idx == `ECIT_IDX_IVL_HI);
endmodule

// File: ecit_pin_model.sv
// Purpose: Drives the two capture pins as an outside logic source would.
// Assumes: Pins change just after a rising mclk edge.
// Notes: Levels are held until the next call of set_pins.
`timescale 1ns/1ns
module ecit_pin_model (
  input wire logic mclk,
  output logic capture_zero_input,
  output logic capture_one_input
);
  initial
  begin
    capture_zero_input = 1'b0;
    capture_one_input = 1'b0;
  end

  // Waits gap edges, then sets both pin levels.
  task automatic set_pins(input logic zero, input logic one, input int gap);
    repeat (gap) @(posedge mclk);
    capture_zero_input <= zero;
    capture_one_input <= one;
  endtask
endmodule

// File: testbench.sv
// Purpose: Register and capture checks of the edge capture timer.
// Assumes: Interval divider set to 2 for a fast interval count.
// Notes: Capture times are checked as differences of edge spacing.
`timescale 1ns/1ns
`include "ecit_defs.svh"
module testbench;
  logic mclk, arst_n, cz, co;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, cap_irq;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, s_axi_bready, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] d0, d1, d2, d3;
  int mismatches, comparisons;
  logic [5:0] tbl_idx [6] = '{`ECIT_IDX_C1F, `ECIT_IDX_CFG, `ECIT_IDX_IEN, `ECIT_IDX_RLD_LO,
                              `ECIT_IDX_RLD_HI, `ECIT_IDX_C0R};
  logic [7:0] tbl_val [6] = '{8'h5a, 8'hff, 8'hff, 8'h34, 8'h1c, 8'ha5};
  logic [7:0] tbl_exp [6] = '{8'h5a, 8'hf8, 8'h0f, 8'h34, 8'h0c, 8'ha5};

  ecit_pin_model pins (.mclk(mclk), .capture_zero_input(cz), .capture_one_input(co));
  ecit_top #(.IVL_DIV(2)) dut (
    .mclk(mclk), .arst_n(arst_n), .capture_zero_input(cz), .capture_one_input(co),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cap_irq(cap_irq));

  // --------------------------------------------------------------------------
  // Bus tasks
  // --------------------------------------------------------------------------
  task automatic axi_write(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] st,
                           output logic [1:0] resp);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a && w))
    begin
      @(posedge mclk);
      a = a | (s_axi_awready === 1'b1);
      w = w | (s_axi_wready === 1'b1);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] resp);
    @(posedge mclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [1:0] r;
    axi_write(idx, d, 4'h1, r);
  endtask

  task automatic rd(input logic [5:0] idx, output logic [31:0] d);
    logic [1:0] r;
    axi_read(idx, d, r);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Clock, reset and watchdog
  // --------------------------------------------------------------------------
  always #10 mclk = ~mclk;

  initial
  begin
    #400000;
    mismatches++;
    complete_run;
  end

  // --------------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    arst_n = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_rready = 1'b0;
    mismatches = 0;
    comparisons = 0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    // Reset values and read-back of each table entry.
    for (int i = 0; i < 6; i++)
    begin
      rd(tbl_idx[i], d0);
      chk(d0, 32'h0);
      wr(tbl_idx[i], tbl_val[i]);
      rd(tbl_idx[i], d0);
      chk(d0, {24'h0, tbl_exp[i]});
    end
    // Unmapped places answer with an error.
    axi_read(6'h3f, d0, rsp);
    chk({d0[29:0], rsp}, {30'h0, `ECIT_RESP_SLVERR});
    axi_write(6'h10, 8'h11, 4'h1, rsp);
    chk({30'h0, rsp}, {30'h0, `ECIT_RESP_SLVERR});
    // A write without lane 0 leaves the register alone.
    axi_write(`ECIT_IDX_CFG, 8'h00, 4'h0, rsp);
    rd(`ECIT_IDX_CFG, d0);
    chk(d0, 32'hf8);
    // Interval count: low read latches the upper nibble.
    wr(`ECIT_IDX_IVL_LO, 8'h08);
    wr(`ECIT_IDX_IVL_HI, 8'h01);
    rd(`ECIT_IDX_IVL_LO, d0);
    repeat (40) @(posedge mclk);
    rd(`ECIT_IDX_IVL_HI, d1);
    chk(d1, 32'h1);
    chk({31'h0, d0[7:0] < 8'h08}, 32'h1);
    wr(`ECIT_IDX_IEN, 8'h05);
    wr(`ECIT_IDX_IST, 8'h0f);
    // Every prescale code: edges 3 slice steps apart.
    for (int p = 0; p < 8; p++)
    begin
      wr(`ECIT_IDX_CFG, {1'b0, p[2:0], 4'h0});
      pins.set_pins(1'b1, 1'b1, 2);
      pins.set_pins(1'b0, 1'b0, 3 << p);
      rd(`ECIT_IDX_C1R, d0);
      rd(`ECIT_IDX_C1F, d1);
      rd(`ECIT_IDX_C0R, d2);
      rd(`ECIT_IDX_C0F, d3);
      chk({24'h0, d1[7:0] - d0[7:0]}, 32'h3);
      chk({24'h0, d3[7:0] - d2[7:0]}, 32'h3);
      rd(`ECIT_IDX_IST, d0);
      chk(d0, 32'h0f);
      chk({28'h0, cap_irq}, 32'h5);
      wr(`ECIT_IDX_IST, 8'h0f);
    end
    // Chained 16-bit capture; channel 1 edges are ignored.
    wr(`ECIT_IDX_CFG, 8'h08);
    pins.set_pins(1'b1, 1'b0, 2);
    pins.set_pins(1'b1, 1'b1, 3);
    pins.set_pins(1'b0, 1'b0, 297);
    rd(`ECIT_IDX_C0R, d0);
    rd(`ECIT_IDX_C1R, d1);
    rd(`ECIT_IDX_C0F, d2);
    rd(`ECIT_IDX_C1F, d3);
    chk({16'h0, {d3[7:0], d2[7:0]} - {d1[7:0], d0[7:0]}}, 32'd300);
    rd(`ECIT_IDX_IST, d0);
    chk(d0, 32'h03);
    chk({28'h0, cap_irq}, 32'h1);
    wr(`ECIT_IDX_IEN, 8'h0a);
    repeat (2) @(posedge mclk);
    chk({28'h0, cap_irq}, 32'h2);
    wr(`ECIT_IDX_IST, 8'h0f);
    repeat (2) @(posedge mclk);
    chk({28'h0, cap_irq}, 32'h0);
    // First-edge hold keeps the first rising edge until read.
    wr(`ECIT_IDX_CFG, 8'h80);
    pins.set_pins(1'b1, 1'b0, 2);
    pins.set_pins(1'b0, 1'b0, 5);
    pins.set_pins(1'b1, 1'b0, 7);
    rd(`ECIT_IDX_C0F, d1);
    rd(`ECIT_IDX_C0R, d0);
    chk({24'h0, d1[7:0] - d0[7:0]}, 32'h5);
    pins.set_pins(1'b0, 1'b0, 2);
    pins.set_pins(1'b1, 1'b0, 4);
    rd(`ECIT_IDX_C0R, d0);
    rd(`ECIT_IDX_C0F, d1);
    chk({24'h0, d0[7:0] - d1[7:0]}, 32'h4);
    complete_run;
  end
endmodule
